/* File: common/aps_pkg.sv */
// Package of register map, codes and constants for the analogue sub-audio and voice path
`default_nettype none
package aps_pkg;
  localparam logic [7:0]  ADDR_TX_MODE    = 8'hb5;
  localparam logic [7:0]  ADDR_RX_STATUS  = 8'hb8;
  localparam logic [7:0]  ADDR_LEVEL_CTRL = 8'hc3;
  localparam logic [15:0] RESET_WORD      = 16'h0000;
  // Sub-audio code space
  localparam logic [7:0]  DCS_NONE        = 8'h00;
  localparam logic [7:0]  DCS_LAST_STD    = 8'h53;
  localparam logic [7:0]  DCS_USER        = 8'h54;
  localparam logic [7:0]  DCS_INV_OFS     = 8'h64;
  localparam logic [7:0]  DCS_INV_USER    = 8'hb8;
  localparam logic [7:0]  CT_NONE         = 8'hc8;
  localparam logic [7:0]  CT_FIRST        = 8'hc9;
  localparam logic [7:0]  CT_LAST_STD     = 8'hfb;
  localparam logic [7:0]  CT_SPLIT_FIRST  = 8'hef;
  localparam logic [7:0]  CT_USER         = 8'hfc;
  localparam logic [7:0]  CT_PHASE        = 8'hfd;
  localparam logic [7:0]  CT_DCS_OFF      = 8'hfe;
  localparam logic [7:0]  CT_INVALID      = 8'hff;
  localparam int          NUM_CTCSS       = 51;
  localparam int          NUM_DCS         = 83;
  // Level control word: top nibble selects field, low byte is the level
  localparam int          LVL_SEL_POS     = 12;
  localparam logic [3:0]  LVL_SEL_VOICE   = 4'h1;
  localparam logic [3:0]  LVL_SEL_INBAND  = 4'h6;
  localparam logic [3:0]  LVL_SEL_SUB     = 4'h7;
  localparam logic [7:0]  LVL_RESET       = 8'h80;
  // Filter corners and turn-off tone in Hz, phase-step threshold in degrees
  localparam int          HPF_HZ          = 300;
  localparam int          NARROW_HZ       = 2550;
  localparam int          WIDE_HZ         = 3000;
  localparam int          CHEB_HZ         = 260;
  localparam int          TURNOFF_HZ      = 134;
  localparam int          PHASE_THRESH_DEG = 90;
  // Turn-off tone burst length
  localparam int          TURNOFF_US      = 150000;
  localparam int          CLK_MHZ         = 200;
  localparam int          TURNOFF_CYC     = TURNOFF_US * CLK_MHZ;
  typedef enum logic [2:0] {
    APS_SUB_NONE, APS_SUB_CTCSS, APS_SUB_DCS, APS_SUB_DCS_INV, APS_SUB_PHASE, APS_SUB_TURNOFF
  } aps_sub_e;
endpackage : aps_pkg
`default_nettype wire

/* File: common/aps_code_if.sv */
// Interface carrying decoded sub-audio selections between modules
`timescale 1ns/1ps
`default_nettype none
interface aps_code_if;
  logic [7:0]         code;
  aps_pkg::aps_sub_e  kind;
  logic [6:0]         index;
  logic               split;
  modport src (output kind, output index, output split, input code);
  modport dst (input kind, input index, input split, output code);
endinterface : aps_code_if
`default_nettype wire

/* File: hdl/aps_code_decode.sv */
// Classifier of a sub-audio selection value into kind and table index
`timescale 1ns/1ps
`default_nettype none
module aps_code_decode (
  aps_code_if.src cif
);
  always_comb begin
    cif.kind  = aps_pkg::APS_SUB_NONE;
    cif.index = 7'h00;
    cif.split = 1'b0;
    if (cif.code >= 8'h01 && cif.code <= aps_pkg::DCS_USER) begin
      cif.kind  = aps_pkg::APS_SUB_DCS;
      cif.index = cif.code[6:0];
    end else if (cif.code > aps_pkg::DCS_INV_OFS && cif.code <= aps_pkg::DCS_INV_USER) begin
      cif.kind  = aps_pkg::APS_SUB_DCS_INV;
      cif.index = 7'(cif.code - aps_pkg::DCS_INV_OFS);
    end else if (cif.code >= aps_pkg::CT_FIRST && cif.code <= aps_pkg::CT_USER) begin
      cif.kind  = aps_pkg::APS_SUB_CTCSS;
      cif.index = 7'(cif.code - aps_pkg::CT_NONE);
      cif.split = (cif.code >= aps_pkg::CT_SPLIT_FIRST) && (cif.code <= aps_pkg::CT_LAST_STD);
    end else if (cif.code == aps_pkg::CT_PHASE) begin
      cif.kind  = aps_pkg::APS_SUB_PHASE;
    end else if (cif.code == aps_pkg::CT_DCS_OFF) begin
      cif.kind  = aps_pkg::APS_SUB_TURNOFF;
    end
  end
endmodule : aps_code_decode
`default_nettype wire

/* File: hdl/aps_phase_detect.sv */
// Detector of large sub-audio phase steps between consecutive phase samples
`timescale 1ns/1ps
`default_nettype none
module aps_phase_detect (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       enable,
  input  wire logic       sample_valid,
  input  wire logic [7:0] phase,
  output logic            step
);
  typedef struct packed {
    logic [7:0] last;
    logic       primed;
    logic       step;
  } aps_pd_s;
  aps_pd_s s_q, s_d;
  logic [7:0] diff;
  assign step = s_q.step;
  always_comb begin
    s_d      = s_q;
    diff     = 8'(phase - s_q.last);
    s_d.step = 1'b0;
    if (sample_valid) begin
      s_d.last   = phase;
      s_d.primed = 1'b1;
      // Phase is 256 counts per turn: beyond 64 counts either way is over a quarter turn
      if (enable && s_q.primed && diff > 8'h40 && diff < 8'hc0) s_d.step = 1'b1;
    end
    if (!enable) s_d.primed = 1'b0;
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) s_q <= '0;
    else s_q <= s_d;
  end
endmodule : aps_phase_detect
`default_nettype wire

/* File: hdl/aps_subaudio_path.sv */
// Analogue sub-audio and voice path control: registers, filter select, sub-audio tx/rx control
`timescale 1ns/1ps
`default_nettype none
module aps_subaudio_path (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rdata,
  // Mode and program-block parameters
  input  wire logic        tx_mode,
  input  wire logic        iq_rx_mode,
  input  wire logic        digital_request,
  input  wire logic        wide_channel_select_bit,
  input  wire logic        phase_change_detect_enable,
  input  wire logic        hpf_enable,
  input  wire logic        agc_enable,
  input  wire logic [15:0] agc_threshold_param,
  input  wire logic [15:0] agc_maxgain_decay_param,
  input  wire logic [15:0] limiter_threshold_param,
  input  wire logic [15:0] subtone_detect_bandwidth_param,
  input  wire logic [15:0] dcs_bessel_param,
  input  wire logic        tail_invert_request,
  // Sub-audio detector results, from the receive datapath
  input  wire logic        rx_det_valid,
  input  wire logic [7:0]  rx_det_code,
  input  wire logic        rx_phase_valid,
  input  wire logic [7:0]  rx_phase,
  // Datapath control
  output logic             sub_gen_enable,
  output logic             sub_gen_is_dcs,
  output logic             sub_gen_dcs_invert,
  output logic [6:0]       sub_gen_index,
  output logic             sub_gen_phase_step,
  output logic             sub_gen_turnoff_tone,
  output logic             sub_det_enable,
  output logic             sub_filter_chebyshev,
  output logic [15:0]      sub_filter_param,
  output logic [15:0]      sub_det_bandwidth,
  output logic             sub_det_split_warn,
  output logic             chan_filter_wide,
  output logic [11:0]      chan_rolloff_hz,
  output logic             hpf_active,
  output logic             emphasis_tx_pre,
  output logic             emphasis_rx_de,
  output logic             inband_gen_enable,
  output logic [15:0]      limiter_threshold,
  output logic             anti_splatter_enable,
  output logic             agc_active,
  output logic [15:0]      agc_threshold,
  output logic [15:0]      agc_maxgain_decay,
  output logic [7:0]       level_voice,
  output logic [7:0]       level_inband,
  output logic [7:0]       level_subaudio,
  output logic             modulator_outputs_invert,
  output logic             digital_inhibit,
  output logic             parallel_mode_allowed
);
  typedef struct packed {
    logic [7:0]  tx_code;
    logic [7:0]  rx_code;
    logic [7:0]  lvl_voice;
    logic [7:0]  lvl_inband;
    logic [7:0]  lvl_sub;
    logic        phase_step;
    logic        turnoff;
    logic [31:0] turnoff_cnt;
    logic        invert;
    logic [15:0] rdata;
    logic        inhibit;
  } aps_top_s;
  aps_top_s s_q, s_d;
  aps_code_if tx_if ();
  aps_code_if rx_if ();
  logic       pd_step;
  logic       is_ctcss;
  logic       is_dcs;
  logic       wr_level;
  assign tx_if.code = s_q.tx_code;
  assign rx_if.code = s_q.rx_code;
  aps_code_decode u_tx_dec (
    .cif (tx_if)
  );
  aps_code_decode u_rx_dec (
    .cif (rx_if)
  );
  aps_phase_detect u_phase (
    .mclk         (mclk),
    .sys_rst      (sys_rst),
    .enable       (phase_change_detect_enable && !tx_mode),
    .sample_valid (rx_phase_valid),
    .phase        (rx_phase),
    .step         (pd_step)
  );
  assign is_ctcss = (tx_if.kind == aps_pkg::APS_SUB_CTCSS);
  assign is_dcs   = (tx_if.kind == aps_pkg::APS_SUB_DCS) || (tx_if.kind == aps_pkg::APS_SUB_DCS_INV);
  assign wr_level = reg_wr && (reg_addr == aps_pkg::ADDR_LEVEL_CTRL);
  always_comb begin
    s_d            = s_q;
    s_d.phase_step = 1'b0;
    if (wr_level) begin
      unique case (reg_wdata[aps_pkg::LVL_SEL_POS +: 4])
        aps_pkg::LVL_SEL_VOICE:  s_d.lvl_voice  = reg_wdata[7:0];
        aps_pkg::LVL_SEL_INBAND: s_d.lvl_inband = reg_wdata[7:0];
        aps_pkg::LVL_SEL_SUB:    s_d.lvl_sub    = reg_wdata[7:0];
        default: ;
      endcase
      if (tx_mode && is_ctcss) s_d.phase_step = 1'b1;
    end
    // Turn-off tone runs for a fixed burst after the selection asks for it
    if (tx_mode && tx_if.kind == aps_pkg::APS_SUB_TURNOFF && s_q.turnoff_cnt < 32'(aps_pkg::TURNOFF_CYC)) begin
      s_d.turnoff     = 1'b1;
      s_d.turnoff_cnt = s_q.turnoff_cnt + 32'd1;
    end else begin
      s_d.turnoff = 1'b0;
    end
    // Placed after the burst logic so a new selection also stops a running burst and clears its count
    if (reg_wr && reg_addr == aps_pkg::ADDR_TX_MODE) begin
      s_d.tx_code = reg_wdata[7:0];
      s_d.turnoff     = 1'b0;
      s_d.turnoff_cnt = '0;
    end
    s_d.invert = tx_mode && tail_invert_request;
    // Detected code latched from the datapath; a phase step overrides it
    if (!tx_mode && rx_det_valid) s_d.rx_code = rx_det_code;
    if (pd_step) s_d.rx_code = aps_pkg::CT_PHASE;
    s_d.rdata = (reg_rd && reg_addr == aps_pkg::ADDR_RX_STATUS) ? {8'h00, s_d.rx_code} : 16'h0000;
    s_d.inhibit = wide_channel_select_bit && iq_rx_mode;
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q            <= '0;
      s_q.rx_code    <= aps_pkg::CT_INVALID;
      s_q.lvl_voice  <= aps_pkg::LVL_RESET;
      s_q.lvl_inband <= aps_pkg::LVL_RESET;
      s_q.lvl_sub    <= aps_pkg::LVL_RESET;
    end else begin
      s_q <= s_d;
    end
  end
  // Generator control; unknown codes decode to no sub-audio
  assign sub_gen_enable       = tx_mode && (is_ctcss || is_dcs);
  assign sub_gen_is_dcs       = is_dcs;
  assign sub_gen_dcs_invert   = (tx_if.kind == aps_pkg::APS_SUB_DCS_INV);
  assign sub_gen_index        = tx_if.index;
  assign sub_gen_phase_step   = s_q.phase_step;
  assign sub_gen_turnoff_tone = s_q.turnoff;
  assign sub_det_enable       = !tx_mode;
  // Filter follows the active sub-audio kind; detector side follows the configured code
  assign sub_filter_chebyshev = tx_mode ? is_ctcss : (s_q.tx_code >= aps_pkg::CT_NONE);
  assign sub_filter_param     = dcs_bessel_param;
  assign sub_det_bandwidth    = subtone_detect_bandwidth_param;
  assign sub_det_split_warn   = tx_if.split;
  assign chan_filter_wide     = wide_channel_select_bit;
  assign chan_rolloff_hz      = wide_channel_select_bit ? 12'(aps_pkg::WIDE_HZ) : 12'(aps_pkg::NARROW_HZ);
  assign hpf_active           = hpf_enable;
  assign emphasis_tx_pre      = tx_mode;
  assign emphasis_rx_de       = !tx_mode;
  assign inband_gen_enable    = 1'b1;
  assign limiter_threshold    = limiter_threshold_param;
  assign anti_splatter_enable = tx_mode;
  assign agc_active           = agc_enable && tx_mode;
  assign agc_threshold        = agc_threshold_param;
  assign agc_maxgain_decay    = agc_maxgain_decay_param;
  assign level_voice          = s_q.lvl_voice;
  assign level_inband         = s_q.lvl_inband;
  assign level_subaudio       = s_q.lvl_sub;
  assign modulator_outputs_invert = s_q.invert;
  assign digital_inhibit      = s_q.inhibit;
  assign parallel_mode_allowed = !wide_channel_select_bit && digital_request;
  assign reg_rdata            = s_q.rdata;
endmodule : aps_subaudio_path
`default_nettype wire

/* File: bench/aps_subaudio_monitor.sv */
// Checker of register, channel-filter and level behaviour at the sub-audio path ports
`timescale 1ns/1ps
`default_nettype none
module aps_subaudio_monitor (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        tx_mode,
  input wire logic        iq_rx_mode,
  input wire logic        wide_channel_select_bit,
  input wire logic [15:0] limiter_threshold_param,
  input wire logic [15:0] limiter_threshold,
  input wire logic        chan_filter_wide,
  input wire logic [11:0] chan_rolloff_hz,
  input wire logic        parallel_mode_allowed,
  input wire logic        digital_inhibit,
  input wire logic [7:0]  level_voice,
  input wire logic [7:0]  level_subaudio,
  input wire logic        sub_gen_enable,
  input wire logic        sub_gen_is_dcs,
  input wire logic        sub_gen_phase_step
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  chk_status_read_high: assert property (reg_rd && reg_addr == aps_pkg::ADDR_RX_STATUS |=> reg_rdata[15:8] == 8'h00)
    else $error("status read upper byte not zero");
  chk_other_read_zero: assert property (reg_rd && reg_addr != aps_pkg::ADDR_RX_STATUS |=> reg_rdata == 16'h0000)
    else $error("read of a non-readable place not zero");
  chk_wide_follows_bit: assert property (chan_filter_wide == wide_channel_select_bit)
    else $error("channel filter width differs from select bit");
  chk_rolloff_value: assert property (chan_rolloff_hz == (chan_filter_wide ? 12'hbb8 : 12'h9f6))
    else $error("roll-off corner wrong for filter width");
  chk_parallel_narrow: assert property (chan_filter_wide |-> !parallel_mode_allowed)
    else $error("parallel mode allowed in wide setting");
  chk_wide_iq_inhibit: assert property (wide_channel_select_bit && iq_rx_mode |=> digital_inhibit)
    else $error("digital operation not inhibited");
  chk_sub_level_write: assert property (reg_wr && reg_addr == aps_pkg::ADDR_LEVEL_CTRL && reg_wdata[15:12] == 4'h7
    |=> level_subaudio == $past(reg_wdata[7:0]) && $stable(level_voice)) else $error("sub-audio level write wrong");
  chk_phase_on_write: assert property (reg_wr && reg_addr == aps_pkg::ADDR_LEVEL_CTRL && reg_wdata[15:12] == 4'h7
    && tx_mode && sub_gen_enable && !sub_gen_is_dcs |=> sub_gen_phase_step) else $error("no phase step on level write");
  chk_step_has_cause: assert property ($rose(sub_gen_phase_step) |-> $past(reg_wr) && $past(reg_addr) == 8'hc3)
    else $error("phase step without level write");
  chk_limiter_param: assert property (limiter_threshold == limiter_threshold_param)
    else $error("limiter threshold not taken from parameter");
endmodule : aps_subaudio_monitor
bind aps_subaudio_path aps_subaudio_monitor u_mon (.*);
`default_nettype wire

/* File: bench/aps_subaudio_path_tb.sv */
// Self-checking testbench of the sub-audio and voice path control block
`timescale 1ns/1ps
`default_nettype none
module aps_subaudio_path_tb;
  logic        mclk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, tx_mode = 1'b0, iq_rx_mode = 1'b0;
  logic        digital_request = 1'b1, wide_channel_select_bit = 1'b0, phase_change_detect_enable = 1'b0;
  logic        hpf_enable = 1'b1, agc_enable = 1'b1, tail_invert_request = 1'b0, rx_det_valid = 1'b0;
  logic        rx_phase_valid = 1'b0;
  logic [7:0]  reg_addr = 8'h00, rx_det_code = 8'h00, rx_phase = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, agc_threshold_param = 16'h1234, agc_maxgain_decay_param = 16'h2345;
  logic [15:0] limiter_threshold_param = 16'h3456, subtone_detect_bandwidth_param = 16'h4567;
  logic [15:0] dcs_bessel_param = 16'h5678;
  logic [15:0] reg_rdata, sub_filter_param, sub_det_bandwidth, limiter_threshold, agc_threshold, agc_maxgain_decay;
  logic [11:0] chan_rolloff_hz;
  logic [7:0]  level_voice, level_inband, level_subaudio;
  logic [6:0]  sub_gen_index;
  logic        sub_gen_enable, sub_gen_is_dcs, sub_gen_dcs_invert, sub_gen_phase_step, sub_gen_turnoff_tone;
  logic        sub_det_enable, sub_filter_chebyshev, sub_det_split_warn, chan_filter_wide, hpf_active;
  logic        emphasis_tx_pre, emphasis_rx_de, inband_gen_enable, anti_splatter_enable, agc_active;
  logic        modulator_outputs_invert, digital_inhibit, parallel_mode_allowed;
  logic [3:0]  m;
  int          failures = 0, compares = 0;
  // Top nibble {enable, dcs, invert}, low byte the selection value
  localparam logic [11:0] TAB [16] = '{12'h000, 12'h601, 12'h653, 12'h654, 12'h765, 12'h7b8, 12'h055,
                                       12'h0b9, 12'h0c8, 12'h0c7, 12'h4c9, 12'h4fb, 12'h4fc, 12'h064,
                                       12'h0fd, 12'h0fe};
  aps_subaudio_path dut (.*);
  always #2.5 mclk = ~mclk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask : rd
  // Phase sample when ph is set, otherwise a detector result
  task automatic rx(input logic ph, input logic [7:0] v);
    @(negedge mclk);
    rx_phase_valid = ph;
    rx_det_valid = !ph;
    rx_phase = v;
    rx_det_code = v;
    @(negedge mclk);
    rx_phase_valid = 1'b0;
    rx_det_valid = 1'b0;
  endtask : rx
  task automatic wrap_up;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    #20000;
    failures++;
    wrap_up();
  end
  initial begin
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    rd(aps_pkg::ADDR_RX_STATUS, 16'h00ff);
    chk({level_voice, level_inband}, 16'h8080);
    chk({9'h000, sub_det_enable, emphasis_tx_pre, emphasis_rx_de, anti_splatter_enable, agc_active, hpf_active,
         inband_gen_enable}, 16'h0053);
    rd(aps_pkg::ADDR_LEVEL_CTRL, 16'h0000);
    rx(1'b0, 8'hd3);
    rd(aps_pkg::ADDR_RX_STATUS, 16'h00d3);
    rx(1'b1, 8'h00);
    rx(1'b1, 8'h80);
    rd(aps_pkg::ADDR_RX_STATUS, 16'h00d3);
    phase_change_detect_enable = 1'b1;
    rx(1'b1, 8'h00);
    rx(1'b1, 8'h80);
    rd(aps_pkg::ADDR_RX_STATUS, 16'h00fd);
    tx_mode = 1'b1;
    for (int i = 0; i < 16; i++) begin
      wr(aps_pkg::ADDR_TX_MODE, {8'h00, TAB[i][7:0]});
      m = TAB[i][10] ? 4'hf : 4'h8;
      chk({12'h000, m & {sub_gen_enable, sub_gen_is_dcs, sub_gen_dcs_invert, sub_filter_chebyshev}},
          {12'h000, m & {TAB[i][10:8], ~TAB[i][9]}});
    end
    chk({9'h000, sub_det_enable, emphasis_tx_pre, emphasis_rx_de, anti_splatter_enable, agc_active, hpf_active,
         inband_gen_enable}, 16'h002f);
    wr(aps_pkg::ADDR_TX_MODE, 16'h0001);
    chk({9'h000, sub_gen_index}, 16'h0001);
    wr(aps_pkg::ADDR_TX_MODE, 16'h0002);
    chk({9'h000, sub_gen_index}, 16'h0002);
    wr(aps_pkg::ADDR_TX_MODE, 16'h0065);
    chk({9'h000, sub_gen_index}, 16'h0001);
    wr(aps_pkg::ADDR_TX_MODE, 16'h00ee);
    chk({8'h00, sub_det_split_warn, sub_gen_index}, 16'h0026);
    wr(aps_pkg::ADDR_TX_MODE, 16'h00ef);
    chk({8'h00, sub_det_split_warn, sub_gen_index}, 16'h00a7);
    wr(aps_pkg::ADDR_TX_MODE, 16'h00fb);
    chk({8'h00, sub_det_split_warn, sub_gen_index}, 16'h00b3);
    wr(aps_pkg::ADDR_TX_MODE, 16'h00fc);
    chk({8'h00, sub_det_split_warn, sub_gen_index}, 16'h0034);
    wr(aps_pkg::ADDR_TX_MODE, 16'h00fe);
    @(negedge mclk);
    chk({15'h0000, sub_gen_turnoff_tone}, 16'h0001);
    wr(aps_pkg::ADDR_TX_MODE, 16'h00c9);
    chk({15'h0000, sub_gen_turnoff_tone}, 16'h0000);
    wr(aps_pkg::ADDR_LEVEL_CTRL, 16'h1012);
    wr(aps_pkg::ADDR_LEVEL_CTRL, 16'h6034);
    wr(aps_pkg::ADDR_LEVEL_CTRL, 16'h2099);
    wr(aps_pkg::ADDR_LEVEL_CTRL, 16'h7056);
    chk({15'h0000, sub_gen_phase_step}, 16'h0001);
    @(negedge mclk);
    chk({15'h0000, sub_gen_phase_step}, 16'h0000);
    chk({level_voice, level_inband}, 16'h1234);
    chk({8'h00, level_subaudio}, 16'h0056);
    chk({3'h0, chan_filter_wide, chan_rolloff_hz}, 16'h09f6);
    chk({14'h0000, digital_inhibit, parallel_mode_allowed}, 16'h0001);
    tail_invert_request = 1'b1;
    wide_channel_select_bit = 1'b1;
    iq_rx_mode = 1'b1;
    @(negedge mclk);
    @(negedge mclk);
    chk({15'h0000, modulator_outputs_invert}, 16'h0001);
    chk({3'h0, chan_filter_wide, chan_rolloff_hz}, 16'h1bb8);
    chk({14'h0000, digital_inhibit, parallel_mode_allowed}, 16'h0002);
    chk(sub_det_bandwidth, 16'h4567);
    chk(sub_filter_param, 16'h5678);
    chk(agc_threshold, 16'h1234);
    chk(agc_maxgain_decay, 16'h2345);
    chk(limiter_threshold, 16'h3456);
    // Mid-run reset must bring back the power-up selection and sub-audio level
    sys_rst = 1'b1;
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    rd(aps_pkg::ADDR_RX_STATUS, 16'h00ff);
    chk({level_subaudio, 7'h00, sub_gen_enable}, 16'h8000);
    wrap_up();
  end
endmodule : aps_subaudio_path_tb
`default_nettype wire
